// >>> design/link_pkg.sv
/*
  Shared constants, types and helpers for the chained serial frame link.
  Assumes both ends and the bench compile this package first.
*/
package link_pkg;
  localparam int DATA_BITS = 16;
  localparam int WORD_BITS = 17;
  localparam int GROUP_BITS = 51;
  localparam int END_RUN = 18;
  localparam int DELAY_BITS = 69;
  localparam int REPLY_TAIL = 33;
  localparam int MAX_DEVICES = 32;
  localparam int ADDR_W = 5;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 8;
  localparam int ARG_W = 6;
  localparam int SYNC_CNT_W = 12;
  localparam int FIFO_DEPTH = 4;
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 80;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // pin sync reset: link clock low, serial data idle high, indications low
  localparam logic [6:0] PIN_SYNC_RST = 7'h20;
  localparam logic SERIAL_IDLE = 1'b1;
  localparam logic [7:0] CMD_WRITE_BCAST = 8'h01;
  localparam logic [7:0] CMD_WRITE_DEV = 8'h02;
  localparam logic [7:0] CMD_CHAIN_INDEX = 8'h03;
  localparam logic [7:0] CMD_FRAME_SYNC = 8'h04;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h05;
  localparam logic [7:0] CMD_MATRIX_PS = 8'h06;
  localparam logic [7:0] CMD_STBY_EN = 8'h07;
  localparam logic [7:0] CMD_STBY_CLR = 8'h08;
  localparam logic [7:0] CMD_READ = 8'h09;

  typedef enum logic [1:0] {RX_IDLE, RX_HEADER, RX_PAYLOAD, RX_SKIP} rx_state_t;
  typedef enum logic [2:0] {
    MODE_INIT, MODE_NORMAL, MODE_POWER_SAVE, MODE_REF_SHORT, MODE_THERMAL
  } mode_t;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_END} tx_state_t;

  function automatic logic [16:0] with_check(input logic [15:0] w);
    return {w, ~w[0]};
  endfunction
endpackage

// >>> design/chained_frame_link.sv
/*
  The three wires between the controller and a chained device.
  Assumes the bench joins one controller end to one device end.
*/
`timescale 1ns/1ns
interface chained_frame_link;
  logic link_clk;
  logic serial_in;
  logic serial_out_line;
  modport controller(output link_clk, output serial_in, input serial_out_line);
  modport device(input link_clk, input serial_in, output serial_out_line);
endinterface

// >>> design/frame_port_device.sv
/*
  Device end of the chained frame link: receive, consume, forward, reply,
  plus the device mode controller.
  Assumes clk is far faster than the link clock, which it samples as a pin.
*/
// Operation
// - idle keeps clock running, data held high
// - high-to-low fall after idle starts frame
// - header is 16-bit command plus check bit
// - payload groups are three 17-bit words
// - check bit is inverse of bit sixteen
// - eighteen high bits end the frame
// - start may directly follow end pattern
// - driver holds data stable at rising edges
// - up to 32 devices, addresses 0 to 31
// - adopt header index, forward it incremented
// - broadcast write copies payload to every device
// - per-device write keeps last 51 bits
// - words MSB first, blue then green then red
// - frame sync delayed by count minus address
// - controller sends frame sync once, first device
// - soft reset restores function registers only
// - matrix power save on zero data, sync
// - standby enable enters, standby clear leaves
// - zero next frame enters power save
// - reference short off below/above hysteresis
// - thermal shutdown with hysteresis
// - undervoltage forces initialization, clears everything
// - read inserts own 48 bits before end
`timescale 1ns/1ns
module frame_port_device (
  input wire logic clk,
  input wire logic resetn,
  chained_frame_link.device link,
  input wire logic [47:0] rd_data,
  input wire logic undervoltage_lockout,
  input wire logic ref_short_entry,
  input wire logic ref_short_exit,
  input wire logic thermal_off_entry,
  input wire logic thermal_off_exit,
  output logic [15:0] word_data,
  output logic word_valid,
  output logic word_pixel,
  output logic [4:0] dev_addr,
  output logic frame_sync,
  output logic soft_reset,
  output logic frame_error,
  output logic channels_on,
  output link_pkg::mode_t mode
);
  localparam int LC = 6;
  localparam int DI = 5;
  localparam int UV = 4;
  localparam int RSE = 3;
  localparam int RSX = 2;
  localparam int TSE = 1;
  localparam int TSX = 0;
  localparam int DL = link_pkg::DELAY_BITS;
  localparam int ER = link_pkg::END_RUN;
  localparam int TL = link_pkg::REPLY_TAIL;
  localparam int SW = link_pkg::SYNC_CNT_W;

  logic [6:0] raw, s1, s2, s3, lvl, next_lvl;
  logic rise, din_b, uv;
  assign raw = {link.link_clk, link.serial_in, undervoltage_lockout, ref_short_entry,
                ref_short_exit, thermal_off_entry, thermal_off_exit};
  // a change counts only once stages two and three agree
  assign next_lvl = (s2 & s3) | (lvl & (s2 ^ s3));
  assign uv = lvl[UV];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= link_pkg::PIN_SYNC_RST;
      s2 <= link_pkg::PIN_SYNC_RST;
      s3 <= link_pkg::PIN_SYNC_RST;
      lvl <= link_pkg::PIN_SYNC_RST;
      rise <= 1'b0;
      din_b <= link_pkg::SERIAL_IDLE;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
      rise <= next_lvl[LC] & ~lvl[LC];
      din_b <= next_lvl[DI];
    end
  end

  link_pkg::rx_state_t state;
  logic [4:0] cnt, ones_run;
  logic [15:0] sr;
  logic [7:0] cmd, hcmd;
  logic [16:0] word;
  logic word_done, chk_ok, end_seen, hdr_done, bad;
  assign word = {sr, din_b};
  assign hcmd = sr[link_pkg::CMD_MSB:link_pkg::CMD_LSB];
  assign word_done = rise && cnt == 5'(link_pkg::WORD_BITS - 1)
                     && (state == link_pkg::RX_HEADER || state == link_pkg::RX_PAYLOAD);
  assign chk_ok = din_b == ~sr[0];
  // a word of all ones is the end pattern arriving, not a bad word
  assign bad = !chk_ok && !(&word);
  assign end_seen = rise && din_b && ones_run == 5'(ER - 1)
                    && state != link_pkg::RX_IDLE;
  assign hdr_done = word_done && state == link_pkg::RX_HEADER && chk_ok;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ones_run <= '0;
    end else if (uv) begin
      ones_run <= '0;
    end else if (rise) begin
      if (!din_b) begin
        ones_run <= '0;
      end else if (cnt == 5'(link_pkg::WORD_BITS - 1) && ones_run == '0) begin
        // a high check bit follows a low bit, so it never opens an end run
        ones_run <= '0;
      end else if (ones_run != 5'(ER)) begin
        ones_run <= ones_run + 5'd1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= link_pkg::RX_IDLE;
      cnt <= '0;
      sr <= '0;
      cmd <= '0;
      frame_error <= 1'b0;
    end else if (uv) begin
      state <= link_pkg::RX_IDLE;
      cnt <= '0;
      sr <= '0;
      cmd <= '0;
      frame_error <= 1'b0;
    end else begin
      frame_error <= word_done && (state == link_pkg::RX_HEADER ? !chk_ok : bad);
      if (rise) begin
        sr <= {sr[14:0], din_b};
        cnt <= (cnt == 5'(link_pkg::WORD_BITS - 1)) ? '0 : cnt + 5'd1;
        case (state)
          link_pkg::RX_IDLE: begin
            cnt <= '0;
            if (!din_b) begin
              state <= link_pkg::RX_HEADER;
            end
          end
          link_pkg::RX_HEADER: begin
            if (word_done) begin
              state <= chk_ok ? link_pkg::RX_PAYLOAD : link_pkg::RX_SKIP;
              cmd <= hcmd;
            end
          end
          link_pkg::RX_PAYLOAD: begin
            if (word_done && bad) begin
              state <= link_pkg::RX_SKIP;
            end
          end
          link_pkg::RX_SKIP: begin
          end
          default: state <= link_pkg::RX_IDLE;
        endcase
        if (end_seen) begin
          state <= link_pkg::RX_IDLE;
        end
      end
    end
  end

  // forwarding delay line: a group plus an end pattern behind the input
  logic [DL-1:0] dl, next_dl;
  logic [TL-1:0] ins;
  logic [5:0] ins_cnt;
  logic [50:0] reply;
  logic [15:0] idx_word;
  logic dev_end, rd_end;
  assign reply = {link_pkg::with_check(rd_data[47:32]), link_pkg::with_check(rd_data[31:16]),
                  link_pkg::with_check(rd_data[15:0])};
  assign idx_word = {sr[15:link_pkg::ADDR_W], sr[link_pkg::ADDR_W-1:0] + 5'd1};
  assign dev_end = end_seen && cmd == link_pkg::CMD_WRITE_DEV;
  assign rd_end = end_seen && cmd == link_pkg::CMD_READ;

  always_comb begin
    next_dl = {dl[DL-2:0], (ins_cnt != '0) ? ins[TL-1] : din_b};
    if (hdr_done && hcmd == link_pkg::CMD_CHAIN_INDEX) begin
      next_dl[16:0] = link_pkg::with_check(idx_word);
    end
    if (dev_end) begin
      next_dl[DL-1:ER] = '1;
    end
    if (rd_end) begin
      next_dl[ER-1:0] = reply[50:TL];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dl <= '1;
      ins <= '0;
      ins_cnt <= '0;
      link.serial_out_line <= link_pkg::SERIAL_IDLE;
    end else if (uv) begin
      dl <= '1;
      ins <= '0;
      ins_cnt <= '0;
      link.serial_out_line <= link_pkg::SERIAL_IDLE;
    end else if (rise) begin
      dl <= next_dl;
      link.serial_out_line <= dl[DL-1];
      if (rd_end) begin
        ins <= reply[TL-1:0];
        ins_cnt <= 6'(TL);
      end else if (ins_cnt != '0) begin
        ins <= {ins[TL-2:0], 1'b1};
        ins_cnt <= ins_cnt - 6'd1;
      end
    end
  end

  // received words to the user side; groups leave as three beats
  logic [47:0] pend;
  logic [1:0] pend_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend <= '0;
      pend_n <= '0;
      word_data <= '0;
      word_valid <= 1'b0;
      word_pixel <= 1'b0;
    end else if (uv) begin
      pend <= '0;
      pend_n <= '0;
      word_data <= '0;
      word_valid <= 1'b0;
      word_pixel <= 1'b0;
    end else begin
      word_valid <= pend_n != '0;
      word_data <= pend[47:32];
      if (dev_end) begin
        pend <= {dl[67:52], dl[50:35], dl[33:18]};
        pend_n <= 2'd3;
        word_pixel <= 1'b1;
      end else if (word_done && state == link_pkg::RX_PAYLOAD && chk_ok && !(&word)
                   && cmd == link_pkg::CMD_WRITE_BCAST) begin
        pend <= {sr, 32'h0};
        pend_n <= 2'd1;
        word_pixel <= 1'b0;
      end else if (pend_n != '0) begin
        pend <= {pend[31:0], 16'h0};
        pend_n <= pend_n - 2'd1;
      end
    end
  end

  // frame sync: a device waits count minus its own address delay lines, so earlier devices wait longer
  logic [SW-1:0] sync_cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_cnt <= '0;
      frame_sync <= 1'b0;
    end else if (uv) begin
      sync_cnt <= '0;
      frame_sync <= 1'b0;
    end else begin
      frame_sync <= 1'b0;
      if (hdr_done && hcmd == link_pkg::CMD_FRAME_SYNC) begin
        sync_cnt <= SW'((int'(sr[link_pkg::ARG_W-1:0]) - int'(dev_addr))
                        * DL);
      end else if (rise && sync_cnt != '0) begin
        sync_cnt <= sync_cnt - 1'b1;
        frame_sync <= sync_cnt == SW'(1);
      end
    end
  end

  logic stby, mps_armed, data_zero, auto_ps, matrix_ps, pix_nonzero;
  assign pix_nonzero = dev_end && |{dl[67:52], dl[50:35], dl[33:18]};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dev_addr <= '0;
      stby <= 1'b0;
      mps_armed <= 1'b0;
      data_zero <= 1'b1;
      auto_ps <= 1'b0;
      matrix_ps <= 1'b0;
      soft_reset <= 1'b0;
    end else if (uv) begin
      dev_addr <= '0;
      stby <= 1'b0;
      mps_armed <= 1'b0;
      data_zero <= 1'b1;
      auto_ps <= 1'b0;
      matrix_ps <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= hdr_done && hcmd == link_pkg::CMD_SOFT_RESET;
      if (hdr_done && hcmd == link_pkg::CMD_CHAIN_INDEX) begin
        dev_addr <= sr[link_pkg::ADDR_W-1:0];
      end
      if (hdr_done && hcmd == link_pkg::CMD_STBY_EN) begin
        stby <= 1'b1;
      end
      if (hdr_done && hcmd == link_pkg::CMD_STBY_CLR) begin
        stby <= 1'b0;
      end
      if (frame_sync) begin
        auto_ps <= data_zero;
        matrix_ps <= data_zero && mps_armed;
        mps_armed <= 1'b0;
        data_zero <= 1'b1;
      end
      // a command landing on the sync edge still arms the next frame
      if (hdr_done && hcmd == link_pkg::CMD_MATRIX_PS) begin
        mps_armed <= 1'b1;
      end
      if (pix_nonzero) begin
        auto_ps <= 1'b0;
        matrix_ps <= 1'b0;
        data_zero <= 1'b0;
      end
      // pixel memory is elsewhere; the chain address survives too
      if (hdr_done && hcmd == link_pkg::CMD_SOFT_RESET) begin
        stby <= 1'b0;
        mps_armed <= 1'b0;
        auto_ps <= 1'b0;
        matrix_ps <= 1'b0;
        data_zero <= 1'b1;
      end
    end
  end

  logic ref_short, thermal;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_short <= 1'b0;
      thermal <= 1'b0;
      mode <= link_pkg::MODE_INIT;
      channels_on <= 1'b0;
    end else if (uv) begin
      ref_short <= 1'b0;
      thermal <= 1'b0;
      mode <= link_pkg::MODE_INIT;
      channels_on <= 1'b0;
    end else begin
      if (lvl[RSE]) begin
        ref_short <= 1'b1;
      end else if (lvl[RSX]) begin
        ref_short <= 1'b0;
      end
      if (lvl[TSE]) begin
        thermal <= 1'b1;
      end else if (lvl[TSX]) begin
        thermal <= 1'b0;
      end
      channels_on <= !(thermal || ref_short || auto_ps || matrix_ps || stby);
      if (thermal) begin
        mode <= link_pkg::MODE_THERMAL;
      end else if (ref_short) begin
        mode <= link_pkg::MODE_REF_SHORT;
      end else if (auto_ps || matrix_ps || stby) begin
        mode <= link_pkg::MODE_POWER_SAVE;
      end else begin
        mode <= link_pkg::MODE_NORMAL;
      end
    end
  end
endmodule

// >>> design/frame_port_controller.sv
/*
  Controller end of the chained frame link with its word FIFO.
  Assumes the user preloads payload words; the link clock is made here.
*/
`timescale 1ns/1ns
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = link_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp;
  logic [AW:0] count, next_count;
  logic push, pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      end
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule

module frame_port_controller (
  input wire logic clk,
  input wire logic resetn,
  chained_frame_link.controller link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [15:0] req_header,
  input wire logic [7:0] req_words,
  input wire logic word_valid,
  output logic word_ready,
  input wire logic [15:0] word_data,
  output logic underrun,
  output logic ret_bit,
  output logic ret_valid
);
  localparam int HALF = link_pkg::LINK_HALF_CYCLES;

  logic [3:0] div;
  logic fall;
  // data moves on the falling edge so it is steady at the rising one
  assign fall = div == 4'(HALF - 1) && link.link_clk;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div <= '0;
      link.link_clk <= 1'b0;
    end else if (div == 4'(HALF - 1)) begin
      div <= '0;
      link.link_clk <= ~link.link_clk;
    end else begin
      div <= div + 4'd1;
    end
  end

  logic f_valid, f_pop;
  logic [15:0] f_data;
  word_fifo #(.WIDTH(16), .DEPTH(link_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .in_data(word_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  link_pkg::tx_state_t state;
  logic pend;
  logic [15:0] hdr;
  logic [7:0] words_left;
  logic [16:0] tx;
  logic [4:0] bits;
  assign f_pop = fall && state == link_pkg::TX_SHIFT && bits == 5'd1
                 && words_left != '0 && f_valid;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= link_pkg::TX_IDLE;
      pend <= 1'b0;
      req_ready <= 1'b1;
      hdr <= '0;
      words_left <= '0;
      tx <= '0;
      bits <= '0;
      underrun <= 1'b0;
      link.serial_in <= link_pkg::SERIAL_IDLE;
    end else begin
      underrun <= 1'b0;
      if (req_valid && req_ready) begin
        pend <= 1'b1;
        req_ready <= 1'b0;
        hdr <= req_header;
        words_left <= req_words;
      end
      if (fall) begin
        case (state)
          link_pkg::TX_IDLE: begin
            link.serial_in <= link_pkg::SERIAL_IDLE;
            if (pend) begin
              link.serial_in <= 1'b0;
              tx <= link_pkg::with_check(hdr);
              bits <= 5'(link_pkg::WORD_BITS);
              pend <= 1'b0;
              state <= link_pkg::TX_SHIFT;
            end
          end
          link_pkg::TX_SHIFT: begin
            link.serial_in <= tx[16];
            tx <= {tx[15:0], 1'b0};
            bits <= bits - 5'd1;
            if (bits == 5'd1) begin
              if (words_left != '0) begin
                tx <= link_pkg::with_check(f_valid ? f_data : 16'h0);
                underrun <= !f_valid;
                words_left <= words_left - 8'd1;
                bits <= 5'(link_pkg::WORD_BITS);
              end else begin
                bits <= 5'(link_pkg::END_RUN);
                state <= link_pkg::TX_END;
              end
            end
          end
          link_pkg::TX_END: begin
            link.serial_in <= 1'b1;
            bits <= bits - 5'd1;
            if (bits == 5'd1) begin
              state <= link_pkg::TX_IDLE;
              req_ready <= 1'b1;
            end
          end
          default: state <= link_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // returned bits from the chain, sampled mid-bit on the falling edge
  logic r1, r2, r3, r_lvl;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r1 <= link_pkg::SERIAL_IDLE;
      r2 <= link_pkg::SERIAL_IDLE;
      r3 <= link_pkg::SERIAL_IDLE;
      r_lvl <= link_pkg::SERIAL_IDLE;
      ret_bit <= link_pkg::SERIAL_IDLE;
      ret_valid <= 1'b0;
    end else begin
      r1 <= link.serial_out_line;
      r2 <= r1;
      r3 <= r2;
      if (r2 == r3) begin
        r_lvl <= r3;
      end
      ret_valid <= fall;
      if (fall) begin
        ret_bit <= r_lvl;
      end
    end
  end
endmodule

// >>> tb/daisy_chain_frame_port_sva.sv
/*
  Wire-level checks on the link between controller and device ends.
  Assumes the bench feeds it the link signals plus clk and resetn.
*/
`timescale 1ns/1ns
module daisy_chain_frame_port_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic serial_in,
  input wire logic serial_out_line
);
  // a check bit breaks every low run, so 17 link bits is the worst case
  localparam int MAX_LOW = 175;
  localparam int IDLE_SPAN = 2000;
  logic [11:0] low_in;
  logic [11:0] low_out;
  logic [11:0] high_in;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) low_in <= 12'h0;
    else low_in <= serial_in ? 12'h0 : low_in + 12'h1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) low_out <= 12'h0;
    else low_out <= serial_out_line ? 12'h0 : low_out + 12'h1;
  end
  // saturates so a long idle cannot wrap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) high_in <= 12'h0;
    else if (!serial_in) high_in <= 12'h0;
    else if (high_in != 12'hfff) high_in <= high_in + 12'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_clk_high; $rose(link_clk) |-> link_clk [*5] ##1 !link_clk; endproperty
  property p_clk_low; $fell(link_clk) |-> !link_clk [*5] ##1 link_clk; endproperty
  property p_data_change; $changed(serial_in) |-> !link_clk; endproperty
  property p_in_hold; $changed(serial_in) |=> $stable(serial_in) [*8]; endproperty
  property p_out_hold; $changed(serial_out_line) |=> $stable(serial_out_line) [*8]; endproperty
  property p_in_low; low_in <= MAX_LOW; endproperty
  property p_out_low; low_out <= MAX_LOW; endproperty
  property p_idle_out; high_in >= IDLE_SPAN |-> serial_out_line; endproperty
  a_clk_high: assert property (p_clk_high) else $error("link clock high phase wrong");
  a_clk_low: assert property (p_clk_low) else $error("link clock low phase wrong");
  a_data_change: assert property (p_data_change) else $error("serial_in moved at high");
  a_in_hold: assert property (p_in_hold) else $error("serial_in bit too short");
  a_out_hold: assert property (p_out_hold) else $error("serial_out bit too short");
  a_in_low: assert property (p_in_low) else $error("serial_in low run too long");
  a_out_low: assert property (p_out_low) else $error("serial_out low run too long");
  a_idle_out: assert property (p_idle_out) else $error("serial_out not idle high");
  c_start: cover property ($fell(serial_in));
  c_fwd: cover property ($fell(serial_out_line));
  c_idle: cover property (high_in == IDLE_SPAN);
endmodule

// >>> tb/daisy_chain_frame_port_tb.sv
/*
  Self-checking bench: controller end joined to device end over the link.
  Assumes link_pkg, the interface and both ends are compiled first.
*/
`timescale 1ns/1ns
module daisy_chain_frame_port_tb;
  logic clk = 1'b0;
  logic resetn, r_valid, r_ready, w_valid, w_ready, d_valid, d_pixel, under;
  logic [15:0] r_hdr, w_data, d_data;
  logic [7:0] r_words;
  logic [47:0] rd_data;
  logic uv, sync_p, soft_p, err_p, ch_on, ret_b, ret_v;
  logic [1:0] ent, ext;
  logic [4:0] addr, idx;
  link_pkg::mode_t mode;
  logic [16:0] exp_q[$];
  logic [15:0] d;
  int mismatches = 0, checks = 0, n_sync = 0, n_soft = 0, n_err = 0, n_under = 0, seed, t;
  int n_ret = 0;
  chained_frame_link link_if();
  frame_port_controller frame_port_controller_inst(.clk(clk), .resetn(resetn),
    .link(link_if.controller), .req_valid(r_valid), .req_ready(r_ready), .req_header(r_hdr),
    .req_words(r_words), .word_valid(w_valid), .word_ready(w_ready), .word_data(w_data),
    .underrun(under), .ret_bit(ret_b), .ret_valid(ret_v));
  frame_port_device frame_port_device_inst(.clk(clk), .resetn(resetn), .link(link_if.device),
    .rd_data(rd_data), .undervoltage_lockout(uv), .ref_short_entry(ent[0]),
    .ref_short_exit(ext[0]), .thermal_off_entry(ent[1]), .thermal_off_exit(ext[1]),
    .word_data(d_data), .word_valid(d_valid), .word_pixel(d_pixel), .dev_addr(addr),
    .frame_sync(sync_p), .soft_reset(soft_p), .frame_error(err_p), .channels_on(ch_on),
    .mode(mode));
  daisy_chain_frame_port_sva daisy_chain_frame_port_sva_inst(.clk(clk), .resetn(resetn),
    .link_clk(link_if.link_clk), .serial_in(link_if.serial_in),
    .serial_out_line(link_if.serial_out_line));
  always #4 clk = ~clk;
  task chk(input string name, input logic [16:0] exp, input logic [16:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // results appear on the device side; notes are taken in order
  always @(posedge clk) begin
    if (d_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("FAIL word_extra expected none seen %h", {d_pixel, d_data});
      end else chk("word", exp_q.pop_front(), {d_pixel, d_data});
    end
    if (sync_p === 1'b1) n_sync++;
    if (soft_p === 1'b1) n_soft++;
    if (err_p === 1'b1) n_err++;
    if (under === 1'b1) n_under++;
    if (ret_v === 1'b1 && ret_b === 1'b0) n_ret++;
  end
  task push(input logic [15:0] v);
    @(posedge clk);
    #1 w_valid = 1'b1;
    w_data = v;
    do @(posedge clk); while (w_ready !== 1'b1);
    #1 w_valid = 1'b0;
  endtask
  task frame(input logic [15:0] h, input logic [7:0] n);
    @(posedge clk);
    #1 r_valid = 1'b1;
    r_hdr = h;
    r_words = n;
    do @(posedge clk); while (r_ready !== 1'b1);
    #1 r_valid = 1'b0;
    @(posedge clk);
    t = 0;
    while (r_ready !== 1'b1 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    chk("frame_done", 17'h1, {16'h0, r_ready});
  endtask
  task words(input logic px, input int n);
    for (int i = 0; i < n; i++) begin
      d = (i == 0) ? 16'hffff : 16'($random(seed));
      exp_q.push_back({px, d});
      push(d);
    end
  endtask
  task mode_is(input link_pkg::mode_t m, input logic on);
    repeat (40) @(posedge clk);
    chk("mode", 17'(m), 17'(mode));
    chk("channels_on", {16'h0, on}, {16'h0, ch_on});
  endtask
  initial begin
    #(8 * 90000);
    mismatches++;
    end_sim();
  end
  initial begin
    seed = 32'hc115fa61;
    {resetn, r_valid, w_valid, uv, ent, ext} = '0;
    r_hdr = 16'h0;
    r_words = 8'h0;
    w_data = 16'h0;
    rd_data = 48'($random(seed));
    repeat (5) @(posedge clk);
    #1 resetn = 1'b1;
    mode_is(link_pkg::MODE_NORMAL, 1'b1);
    idx = 5'($random(seed));
    frame({link_pkg::CMD_CHAIN_INDEX, 3'h0, idx}, 8'h0);
    repeat (40) @(posedge clk);
    chk("dev_addr", 17'(idx), 17'(addr));
    words(1'b0, 4);
    @(posedge clk);
    #1 chk("fifo_full", 17'h0, {16'h0, w_ready});
    frame({link_pkg::CMD_WRITE_BCAST, 8'h0}, 8'h4);
    words(1'b1, 3);
    frame({link_pkg::CMD_WRITE_DEV, 8'h0}, 8'h3);
    frame({link_pkg::CMD_FRAME_SYNC, 2'h0, 6'(idx) + 6'h1}, 8'h0);
    chk("sync_early", 17'h0, 17'(n_sync));
    t = 0;
    while (n_sync == 0 && t < 1500) begin
      @(posedge clk);
      t++;
    end
    chk("frame_sync", 17'h1, 17'(n_sync));
    // one delay line of 69 link bits, minus the end pattern already sent
    chk("sync_delay", 17'h1, {16'h0, t > 400});
    frame({link_pkg::CMD_SOFT_RESET, 8'h0}, 8'h0);
    repeat (40) @(posedge clk);
    chk("soft_reset", 17'h1, 17'(n_soft));
    chk("addr_kept", 17'(idx), 17'(addr));
    frame({link_pkg::CMD_STBY_EN, 8'h0}, 8'h0);
    mode_is(link_pkg::MODE_POWER_SAVE, 1'b0);
    frame({link_pkg::CMD_STBY_CLR, 8'h0}, 8'h0);
    mode_is(link_pkg::MODE_NORMAL, 1'b1);
    // no pixel data since the last sync, so the next sync powers down
    frame({link_pkg::CMD_MATRIX_PS, 8'h0}, 8'h0);
    frame({link_pkg::CMD_FRAME_SYNC, 2'h0, 6'(idx) + 6'h1}, 8'h0);
    repeat (700) @(posedge clk);
    mode_is(link_pkg::MODE_POWER_SAVE, 1'b0);
    words(1'b1, 3);
    frame({link_pkg::CMD_WRITE_DEV, 8'h0}, 8'h3);
    mode_is(link_pkg::MODE_NORMAL, 1'b1);
    repeat (800) @(posedge clk);
    chk("pending", 17'h0, 17'(exp_q.size()));
    chk("frame_error", 17'h0, 17'(n_err));
    chk("underrun", 17'h0, 17'(n_under));
    for (int k = 0; k < 2; k++) begin
      #1 ent[k] = 1'b1;
      mode_is(k ? link_pkg::MODE_THERMAL : link_pkg::MODE_REF_SHORT, 1'b0);
      #1 ent[k] = 1'b0;
      ext[k] = 1'b1;
      mode_is(link_pkg::MODE_NORMAL, 1'b1);
      #1 ext[k] = 1'b0;
    end
    #1 uv = 1'b1;
    mode_is(link_pkg::MODE_INIT, 1'b0);
    chk("uv_addr", 17'h0, 17'(addr));
    #1 uv = 1'b0;
    mode_is(link_pkg::MODE_NORMAL, 1'b1);
    // long idle lets the forwarded line settle high
    repeat (2100) @(posedge clk);
    chk("ret_forwarded", 17'h1, {16'h0, n_ret > 0});
    chk("ret_idle", 17'h1, {16'h0, ret_b});
    end_sim();
  end
endmodule
